// *** bmo_control.sv ***
// Bank mode and address space overlay control unit for a banked flash
`timescale 1ns/100ps
// Summary of operation
// RQ1: Write AAh low address, data 98h/90h in bank zero enters identification overlay.
// RQ2: Identification overlay entry accepted only while the bank is in read mode.
// RQ3: Reads in the selected sector return overlay contents while overlay active.
// RQ4: Write with low data byte F0h leaves identification overlay.
// RQ5: Identity area at offsets 0-1Fh, parameter table 20h-CEh, both read only.
// RQ6: Identification overlay bytes sit one per word on the low byte, upper byte zero.
// RQ7: Secure overlay: factory half 0000h-00FFh, customer half 0100h-01FFh.
// RQ8: Configuration overlay entry only from read mode, replaces selected sector.
// RQ9: In configuration overlay, write of 00F0h returns to read mode.
// RQ10: Each bank read, algorithm or overlay; at most one bank non-read.
// RQ11: All banks read at reset; reset command ends identification and secure overlays; algorithm end returns.
// RQ12: Ready high only with valid read data; host waits while low.
// RQ13: Commands come only from write cycles and occupy no array locations.
// RQ14: Host issues reset command after wrong or out-of-order cycles.
// RQ15: Algorithm bank gives no array data; other banks stay readable.
// RQ16: Only status read command accepted in algorithm bank.
// RQ17: Algorithm or overlay entry ignored while another bank is busy.
// RQ18: Host finishes or suspends algorithms before overlay entry.
// RQ19: Other banks and other sectors read array data during overlay.
// RQ20: Only the overlaid item programs; bank runs algorithm mode meanwhile.
// RQ21: Programs to identification overlay or factory half fail unchanged.
// RQ22: Bank index is the top four address bits, sixteen equal banks.
module bmo_control #(
  parameter int SECTOR_W = bmo_pkg::SECTOR_W
) (
  input  wire logic                        CLK_SYS_IN,
  input  wire logic                        ARST_N_IN,
  input  wire logic                        WR_VALID_IN,
  input  wire logic [bmo_pkg::ADDR_W-1:0]  WR_ADDR_IN,
  input  wire logic [bmo_pkg::DATA_W-1:0]  WR_DATA_IN,
  input  wire logic                        RD_VALID_IN,
  input  wire logic [bmo_pkg::ADDR_W-1:0]  RD_ADDR_IN,
  input  wire logic [bmo_pkg::DATA_W-1:0]  ARRAY_RDATA_IN,
  input  wire logic [bmo_pkg::DATA_W-1:0]  OVL_RDATA_IN,
  input  wire logic [bmo_pkg::DATA_W-1:0]  STATUS_IN,
  input  wire logic                        ALG_DONE_IN,
  output logic                             MEM_RD_OUT,
  output logic [bmo_pkg::ADDR_W-1:0]       MEM_ADDR_OUT,
  output logic [5:0]                       MEM_SRC_OUT,
  output logic [bmo_pkg::DATA_W-1:0]       RDATA_OUT,
  output logic                             RDY_OUT,
  output logic                             ALG_START_OUT,
  output bmo_pkg::bmo_alg_req_t            ALG_REQ_OUT,
  output logic                             PROG_FAIL_OUT,
  output logic [bmo_pkg::NUM_BANKS-1:0]    BANK_BUSY_OUT
);

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  localparam int SECT_IDX_W = bmo_pkg::ADDR_W - SECTOR_W;

  // Bank index from the top address bits
  function automatic logic [bmo_pkg::BANK_W-1:0] bank_of(
    input logic [bmo_pkg::ADDR_W-1:0] addr
  );
    bank_of = addr[bmo_pkg::ADDR_W-1 -: bmo_pkg::BANK_W];  // [RQ22]
  endfunction : bank_of

  // Sector index inside the whole array
  function automatic logic [SECT_IDX_W-1:0] sector_of(
    input logic [bmo_pkg::ADDR_W-1:0] addr
  );
    sector_of = addr[bmo_pkg::ADDR_W-1:SECTOR_W];
  endfunction : sector_of

  // Word offset inside a sector, zero extended to 16 bits
  function automatic logic [15:0] offset_of(
    input logic [bmo_pkg::ADDR_W-1:0] addr
  );
    logic [15:0] off;
    off = 16'h0000;
    off[SECTOR_W-1:0] = addr[SECTOR_W-1:0];
    offset_of = off;
  endfunction : offset_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bmo_pkg::bmo_mode_t             mode, next_mode;
  bmo_pkg::bmo_ovl_t              ovl, next_ovl;
  logic [bmo_pkg::BANK_W-1:0]     act_bank, next_act_bank;
  logic [SECT_IDX_W-1:0]          sel_sect, next_sel_sect;
  logic                           prog_arm, next_prog_arm;
  logic                           stat_arm, next_stat_arm;
  logic                           ret_aso, next_ret_aso;
  logic                           next_start;
  logic                           next_fail;
  bmo_pkg::bmo_alg_req_t          next_req;
  bmo_pkg::bmo_src_t              next_src;
  logic [bmo_pkg::DATA_W-1:0]     next_rdata;

  // ----------------------------------------------------------------
  // Write cycle decode
  // ----------------------------------------------------------------
  wire logic [7:0]                 cmd_lo   = WR_DATA_IN[7:0];
  wire logic [bmo_pkg::BANK_W-1:0] wr_bank  = bank_of(WR_ADDR_IN);
  wire logic [SECT_IDX_W-1:0]      wr_sect  = sector_of(WR_ADDR_IN);
  wire logic [15:0]                wr_off   = offset_of(WR_ADDR_IN);
  wire logic is_reset   = (cmd_lo == bmo_pkg::CMD_RESET);
  wire logic id_enter   = (wr_bank == '0)
                        && (WR_ADDR_IN[7:0] == bmo_pkg::ID_ENTER_ADDR_LO)
                        && ((cmd_lo == bmo_pkg::CMD_ID_ENTER_A)
                         || (cmd_lo == bmo_pkg::CMD_ID_ENTER_B));  // [RQ1]
  wire logic sec_enter  = (cmd_lo == bmo_pkg::CMD_SEC_ENTER);
  wire logic cfg_enter  = (cmd_lo == bmo_pkg::CMD_CFG_ENTER);
  wire logic prog_cmd   = (cmd_lo == bmo_pkg::CMD_PROGRAM);
  wire logic stat_cmd   = (cmd_lo == bmo_pkg::CMD_STATUS);
  wire logic in_sel     = (wr_bank == act_bank) && (wr_sect == sel_sect);
  // Exit pattern depends on the overlay
  wire logic ovl_exit   = (ovl == bmo_pkg::OVL_CFG)
                        ? (WR_DATA_IN == bmo_pkg::CMD_CFG_EXIT)  // [RQ9]
                        : is_reset;                              // [RQ4]
  // Only the overlaid item may be programmed, never the read-only parts
  wire logic sec_cust   = (wr_off > bmo_pkg::SEC_FACTORY_END)
                        && (wr_off <= bmo_pkg::SEC_END);          // [RQ7]
  wire logic ovl_prog_ok = in_sel && ((ovl == bmo_pkg::OVL_CFG)
                        || ((ovl == bmo_pkg::OVL_SEC) && sec_cust));  // [RQ20] [RQ21]

  // ----------------------------------------------------------------
  // Control unit next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_mode     = mode;
    next_ovl      = ovl;
    next_act_bank = act_bank;
    next_sel_sect = sel_sect;
    next_prog_arm = prog_arm;
    next_stat_arm = stat_arm;
    next_ret_aso  = ret_aso;
    next_start    = 1'b0;
    next_fail     = 1'b0;
    next_req      = ALG_REQ_OUT;
    if ((mode == bmo_pkg::MODE_EA) && ALG_DONE_IN)
    begin
      // Leaving the algorithm: back to read, or to the overlay it came from
      next_mode     = ret_aso ? bmo_pkg::MODE_ASO : bmo_pkg::MODE_READ;  // [RQ11]
      next_stat_arm = 1'b0;
    end
    else if (WR_VALID_IN)  // Commands only from write cycles [RQ13]
    begin
      case (mode)
        bmo_pkg::MODE_READ:
        begin
          if (is_reset)
            next_prog_arm = 1'b0;  // [RQ11]
          else if (prog_arm)
          begin
            next_prog_arm = 1'b0;
            next_mode     = bmo_pkg::MODE_EA;
            next_act_bank = wr_bank;
            next_ret_aso  = 1'b0;
            next_start    = 1'b1;
            next_req      = '{addr: WR_ADDR_IN, data: WR_DATA_IN,
                              to_array: 1'b1, ovl: bmo_pkg::OVL_ID};
          end
          else if (id_enter || sec_enter || cfg_enter)
          begin
            // Entry only from read mode, all banks idle [RQ2] [RQ8] [RQ17]
            next_mode     = bmo_pkg::MODE_ASO;
            next_act_bank = wr_bank;
            next_sel_sect = wr_sect;
            next_ovl      = id_enter  ? bmo_pkg::OVL_ID
                          : sec_enter ? bmo_pkg::OVL_SEC
                          : bmo_pkg::OVL_CFG;
          end
          else if (prog_cmd)
            next_prog_arm = 1'b1;
        end
        bmo_pkg::MODE_EA:
        begin
          // Only the status read is taken by the busy bank [RQ16] [RQ17]
          if ((wr_bank == act_bank) && stat_cmd)
            next_stat_arm = 1'b1;
        end
        bmo_pkg::MODE_ASO:
        begin
          if (prog_arm)
          begin
            next_prog_arm = 1'b0;
            if (ovl_prog_ok)
            begin
              next_mode    = bmo_pkg::MODE_EA;  // [RQ20]
              next_ret_aso = 1'b1;
              next_start   = 1'b1;
              next_req     = '{addr: WR_ADDR_IN, data: WR_DATA_IN,
                               to_array: 1'b0, ovl: ovl};
            end
            else
              next_fail = 1'b1;  // [RQ21]
          end
          else if (ovl_exit)
            next_mode = bmo_pkg::MODE_READ;  // [RQ4] [RQ9]
          else if (prog_cmd && (wr_bank == act_bank))
            next_prog_arm = 1'b1;
        end
        default:
          next_mode = bmo_pkg::MODE_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control unit registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      mode     <= bmo_pkg::MODE_READ;  // [RQ11]
      ovl      <= bmo_pkg::OVL_ID;
      act_bank <= '0;
      sel_sect <= '0;
      prog_arm <= 1'b0;
      stat_arm <= 1'b0;
      ret_aso  <= 1'b0;
    end
    else
    begin
      mode     <= next_mode;  // One shared mode keeps one busy bank [RQ10]
      ovl      <= next_ovl;
      act_bank <= next_act_bank;
      sel_sect <= next_sel_sect;
      prog_arm <= next_prog_arm;
      stat_arm <= next_stat_arm;
      ret_aso  <= next_ret_aso;
    end
  end

  // Algorithm request outputs
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      ALG_START_OUT <= 1'b0;
      ALG_REQ_OUT   <= '0;
      PROG_FAIL_OUT <= 1'b0;
    end
    else
    begin
      ALG_START_OUT <= next_start;
      ALG_REQ_OUT   <= next_req;
      PROG_FAIL_OUT <= next_fail;
    end
  end

  // ----------------------------------------------------------------
  // Per-bank busy flags
  // ----------------------------------------------------------------
  generate
    for (genvar b = 0; b < bmo_pkg::NUM_BANKS; b++)
    begin : g_bank
      always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
      begin
        if (!ARST_N_IN)
          BANK_BUSY_OUT[b] <= 1'b0;
        else
          BANK_BUSY_OUT[b] <= (next_mode != bmo_pkg::MODE_READ)
                           && (next_act_bank == bmo_pkg::BANK_W'(b));  // [RQ10]
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path stage one: source select
  // ----------------------------------------------------------------
  wire logic [bmo_pkg::BANK_W-1:0] rd_bank = bank_of(RD_ADDR_IN);
  wire logic [15:0]                rd_off  = offset_of(RD_ADDR_IN);
  wire logic hit_ea  = (mode == bmo_pkg::MODE_EA) && (rd_bank == act_bank);
  wire logic hit_ovl = (mode == bmo_pkg::MODE_ASO) && (rd_bank == act_bank)
                     && (sector_of(RD_ADDR_IN) == sel_sect);  // [RQ19]
  wire bmo_pkg::bmo_src_t ovl_src =
      (ovl == bmo_pkg::OVL_CFG) ? bmo_pkg::SRC_CFG
    : (ovl == bmo_pkg::OVL_SEC)
        ? ((rd_off <= bmo_pkg::SEC_END) ? bmo_pkg::SRC_SEC : bmo_pkg::SRC_NONE)
    : ((rd_off <= bmo_pkg::ID_TABLE_END) ? bmo_pkg::SRC_ID : bmo_pkg::SRC_NONE);  // [RQ5]
  assign next_src = hit_ea  ? (stat_arm ? bmo_pkg::SRC_STATUS
                                        : bmo_pkg::SRC_NONE)  // [RQ15] [RQ16]
                  : hit_ovl ? ovl_src                       // [RQ3]
                  : bmo_pkg::SRC_ARRAY;                     // [RQ15] [RQ19]

  // Issue the storage read and remember its source
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      MEM_RD_OUT   <= 1'b0;
      MEM_ADDR_OUT <= '0;
      MEM_SRC_OUT  <= bmo_pkg::SRC_NONE;
    end
    else
    begin
      MEM_RD_OUT   <= RD_VALID_IN;
      MEM_ADDR_OUT <= RD_VALID_IN ? RD_ADDR_IN : MEM_ADDR_OUT;
      MEM_SRC_OUT  <= RD_VALID_IN ? next_src : MEM_SRC_OUT;
    end
  end

  // ----------------------------------------------------------------
  // Read path stage two: data select
  // ----------------------------------------------------------------
  always_comb
  begin
    case (MEM_SRC_OUT)
      bmo_pkg::SRC_ARRAY:  next_rdata = ARRAY_RDATA_IN;
      bmo_pkg::SRC_ID:     next_rdata = {bmo_pkg::ZERO_BYTE, OVL_RDATA_IN[7:0]};  // [RQ6]
      bmo_pkg::SRC_SEC:    next_rdata = OVL_RDATA_IN;
      bmo_pkg::SRC_CFG:    next_rdata = OVL_RDATA_IN;
      bmo_pkg::SRC_STATUS: next_rdata = STATUS_IN;  // [RQ16]
      default:             next_rdata = bmo_pkg::ZERO_WORD;
    endcase
  end

  // Data and ready leave together; ready marks valid data only
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      RDATA_OUT <= '0;
      RDY_OUT   <= 1'b0;
    end
    else
    begin
      RDATA_OUT <= MEM_RD_OUT ? next_rdata : RDATA_OUT;
      RDY_OUT   <= MEM_RD_OUT;  // [RQ12]
    end
  end

endmodule : bmo_control

// *** bmo_mem_model.sv ***
// Storage and algorithm engine model behind the bank mode overlay control
`timescale 1ns/100ps
module bmo_mem_model #(
  parameter int FAST_DLY = 4,
  parameter int SLOW_DLY = 40
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        rd_in,
  input  wire logic [23:0] addr_in,
  input  wire logic        start_in,
  input  wire logic        slow_in,
  output logic      [15:0] array_out,
  output logic      [15:0] ovl_out,
  output logic      [15:0] status_out,
  output logic             done_out
);
  logic       [7:0]  cnt;
  wire  logic [15:0] arr_w = addr_in[15:0] ^ 16'h5a5a;
  wire  logic [15:0] ovl_w = {addr_in[7:0] ^ 8'hc3, addr_in[7:0]};
  // Words are valid only in the read cycle, inverted otherwise
  assign array_out  = rd_in ? arr_w : ~arr_w;
  assign ovl_out    = rd_in ? ovl_w : ~ovl_w;
  assign status_out = (cnt != 8'h00) ? 16'h0001 : 16'h0080;
  assign done_out   = (cnt == 8'h01);
  // Algorithm run time, short or long as the bench asks
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      cnt <= 8'h00;
    else if (start_in)
      cnt <= slow_in ? 8'(SLOW_DLY) : 8'(FAST_DLY);
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
endmodule : bmo_mem_model

// *** bmo_pkg.sv ***
// Shared constants, encodings and carrier types for the bank mode overlay control
package bmo_pkg;

  // ----------------------------------------------------------------
  // Bus widths and address split
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 24;   // Word address width
  localparam int DATA_W     = 16;   // Word data width
  localparam int BANK_W     = 4;    // Sixteen equal banks
  localparam int NUM_BANKS  = 16;
  localparam int SECTOR_W   = 16;   // Word address bits inside one sector

  // ----------------------------------------------------------------
  // Command codes (low data byte unless noted)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ID_ENTER_ADDR_LO = 8'haa;
  localparam logic [7:0]  CMD_ID_ENTER_A   = 8'h98;
  localparam logic [7:0]  CMD_ID_ENTER_B   = 8'h90;
  localparam logic [7:0]  CMD_RESET        = 8'hf0;
  localparam logic [15:0] CMD_CFG_EXIT     = 16'h00f0;  // Full word
  localparam logic [7:0]  CMD_SEC_ENTER    = 8'h88;
  localparam logic [7:0]  CMD_CFG_ENTER    = 8'hd0;
  localparam logic [7:0]  CMD_PROGRAM      = 8'ha0;
  localparam logic [7:0]  CMD_STATUS       = 8'h70;

  // ----------------------------------------------------------------
  // Overlay layout, word offsets inside the selected sector
  // ----------------------------------------------------------------
  localparam logic [15:0] ID_AREA_END      = 16'h001f;  // Identity bytes
  localparam logic [15:0] ID_TABLE_END     = 16'h00ce;  // Parameter table end
  localparam logic [15:0] SEC_FACTORY_END  = 16'h007f;  // Byte 00ffh
  localparam logic [15:0] SEC_END          = 16'h00ff;  // Byte 01ffh
  localparam logic [7:0]  ZERO_BYTE        = 8'h00;
  localparam logic [15:0] ZERO_WORD        = 16'h0000;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_READ = 3'b001,
    MODE_EA   = 3'b010,
    MODE_ASO  = 3'b100
  } bmo_mode_t;

  typedef enum logic [2:0] {
    OVL_ID  = 3'b001,
    OVL_SEC = 3'b010,
    OVL_CFG = 3'b100
  } bmo_ovl_t;

  typedef enum logic [5:0] {
    SRC_ARRAY  = 6'b000001,
    SRC_ID     = 6'b000010,
    SRC_SEC    = 6'b000100,
    SRC_CFG    = 6'b001000,
    SRC_STATUS = 6'b010000,
    SRC_NONE   = 6'b100000
  } bmo_src_t;

  // ----------------------------------------------------------------
  // Carrier for a program request handed to the algorithm engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              to_array;   // Plain array word
    bmo_ovl_t          ovl;        // Overlaid item when not array
  } bmo_alg_req_t;

endpackage : bmo_pkg

// *** bmo_props.sv ***
// Port-level assertions for the bank mode overlay control
`timescale 1ns/100ps
module bmo_props (
  input wire logic                  CLK_SYS_IN,
  input wire logic                  ARST_N_IN,
  input wire logic                  WR_VALID_IN,
  input wire logic                  RD_VALID_IN,
  input wire logic [23:0]           RD_ADDR_IN,
  input wire logic [15:0]           ARRAY_RDATA_IN,
  input wire logic [15:0]           OVL_RDATA_IN,
  input wire logic [15:0]           STATUS_IN,
  input wire logic                  MEM_RD_OUT,
  input wire logic [23:0]           MEM_ADDR_OUT,
  input wire logic [5:0]            MEM_SRC_OUT,
  input wire logic [15:0]           RDATA_OUT,
  input wire logic                  RDY_OUT,
  input wire logic                  ALG_START_OUT,
  input wire bmo_pkg::bmo_alg_req_t ALG_REQ_OUT,
  input wire logic                  PROG_FAIL_OUT,
  input wire logic [15:0]           BANK_BUSY_OUT
);
  // ----------------------------------------------------------------
  // Read pipeline, sources and bank modes
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire logic [3:0] rd_bank = RD_ADDR_IN[23:20];
  a_read_latency: assert property (RD_VALID_IN |-> ##2 RDY_OUT)
    else $error("ready missing two cycles after a read");
  a_ready_cause: assert property (RDY_OUT |-> $past(MEM_RD_OUT))
    else $error("ready without a storage read");
  a_mem_addr: assert property (RD_VALID_IN |=>
    MEM_RD_OUT && MEM_ADDR_OUT == $past(RD_ADDR_IN))
    else $error("storage read address wrong");
  a_single_bank: assert property ($onehot0(BANK_BUSY_OUT))
    else $error("more than one bank busy");
  a_idle_bank_array: assert property (RD_VALID_IN && !BANK_BUSY_OUT[rd_bank] |=>
    MEM_SRC_OUT == bmo_pkg::SRC_ARRAY)
    else $error("read mode bank not served from array");
  a_array_data: assert property (MEM_RD_OUT && MEM_SRC_OUT == bmo_pkg::SRC_ARRAY |=>
    RDATA_OUT == $past(ARRAY_RDATA_IN))
    else $error("array word not returned");
  a_id_low_byte: assert property (MEM_RD_OUT && MEM_SRC_OUT == bmo_pkg::SRC_ID |=>
    RDATA_OUT == ($past(OVL_RDATA_IN) & 16'h00ff))
    else $error("identity byte not on low half");
  a_status_word: assert property (MEM_RD_OUT && MEM_SRC_OUT == bmo_pkg::SRC_STATUS |=>
    RDATA_OUT == $past(STATUS_IN))
    else $error("status word not returned");
  a_start_busy: assert property (ALG_START_OUT |->
    BANK_BUSY_OUT[ALG_REQ_OUT.addr[23:20]])
    else $error("program started in a bank not busy");
  a_busy_cause: assert property (BANK_BUSY_OUT != 16'h0000 &&
    $past(BANK_BUSY_OUT) == 16'h0000 |-> $past(WR_VALID_IN))
    else $error("bank left read mode without a write");
  a_fail_cause: assert property (PROG_FAIL_OUT |-> $past(WR_VALID_IN) && !ALG_START_OUT)
    else $error("program refusal without a write");
  c_id_read: cover property (RDY_OUT && $past(MEM_SRC_OUT) == bmo_pkg::SRC_ID);
  c_status_read: cover property (RDY_OUT && $past(MEM_SRC_OUT) == bmo_pkg::SRC_STATUS);
  c_start: cover property (ALG_START_OUT);
  c_fail: cover property (PROG_FAIL_OUT);
endmodule : bmo_props
bind bmo_control bmo_props i_props (
  .CLK_SYS_IN(CLK_SYS_IN), .ARST_N_IN(ARST_N_IN), .WR_VALID_IN(WR_VALID_IN),
  .RD_VALID_IN(RD_VALID_IN), .RD_ADDR_IN(RD_ADDR_IN), .ARRAY_RDATA_IN(ARRAY_RDATA_IN),
  .OVL_RDATA_IN(OVL_RDATA_IN), .STATUS_IN(STATUS_IN), .MEM_RD_OUT(MEM_RD_OUT),
  .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_SRC_OUT(MEM_SRC_OUT), .RDATA_OUT(RDATA_OUT),
  .RDY_OUT(RDY_OUT), .ALG_START_OUT(ALG_START_OUT), .ALG_REQ_OUT(ALG_REQ_OUT),
  .PROG_FAIL_OUT(PROG_FAIL_OUT), .BANK_BUSY_OUT(BANK_BUSY_OUT)
);

// *** bmo_tb.sv ***
// Self-checking testbench for the bank mode overlay control
`timescale 1ns/100ps
module testbench;
  logic                  clk = 1'h0, rst_n = 1'h0, wr_v = 1'h0, rd_v = 1'h0, slow = 1'h0;
  logic [23:0]           wr_a = 24'h0, rd_a = 24'h0, mem_a;
  logic [15:0]           wr_d = 16'h0, arr_d, ovl_d, st_d, rdata, busy, code;
  logic                  done, mem_rd, rdy, start, fail;
  logic [5:0]            src;
  bmo_pkg::bmo_alg_req_t req;
  logic [15:0]           rq[$];
  logic [41:0]           pq[$];
  logic [31:0]           seed = 32'hf6a9e824;
  logic [15:0]           id_off[5] = '{16'h0000, 16'h001f, 16'h0020, 16'h00ce, 16'h00cf};
  logic [15:0]           sec_off[5] = '{16'h0000, 16'h007f, 16'h0080, 16'h00ff, 16'h0100};
  int                    errors = 0;
  int                    n_tests = 0;
  always #12.5 clk = ~clk;
  bmo_control i_dut (
    .CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .WR_VALID_IN(wr_v), .WR_ADDR_IN(wr_a),
    .WR_DATA_IN(wr_d), .RD_VALID_IN(rd_v), .RD_ADDR_IN(rd_a), .ARRAY_RDATA_IN(arr_d),
    .OVL_RDATA_IN(ovl_d), .STATUS_IN(st_d), .ALG_DONE_IN(done), .MEM_RD_OUT(mem_rd),
    .MEM_ADDR_OUT(mem_a), .MEM_SRC_OUT(src), .RDATA_OUT(rdata), .RDY_OUT(rdy),
    .ALG_START_OUT(start), .ALG_REQ_OUT(req), .PROG_FAIL_OUT(fail), .BANK_BUSY_OUT(busy));
  bmo_mem_model i_mem (
    .clk_in(clk), .rst_n_in(rst_n), .rd_in(mem_rd), .addr_in(mem_a), .start_in(start),
    .slow_in(slow), .array_out(arr_d), .ovl_out(ovl_d), .status_out(st_d), .done_out(done));
  // ----------------------------------------------------------------
  // Expected words and comparisons
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [15:0] arr_w(input logic [23:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction : arr_w
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_prog(input logic [41:0] exp, input logic [41:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value program result expected %h seen %h", exp, got);
    end
  endtask : check_prog
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Host bus drivers, each change just after a rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    {wr_v, rd_v, wr_a, wr_d} = {2'h2, a, d};
    @(posedge clk) #1;
  endtask : wr
  task automatic rd(input logic [23:0] a, input logic [15:0] exp);
    {wr_v, rd_v, rd_a} = {2'h1, a};
    rq.push_back(exp);
    @(posedge clk) #1;
  endtask : rd
  task automatic idle(input int n);
    {wr_v, rd_v} = 2'h0;
    repeat (n) @(posedge clk) #1;
  endtask : idle
  task automatic busy_is(input logic [15:0] exp);
    idle(1);
    for (int i = 0; i < 100 && busy !== exp; i++) @(posedge clk) #1;
    check_word("bank busy", exp, busy);
  endtask : busy_is
  task automatic prog(input logic [23:0] a, input logic [15:0] d, input logic ok, input logic arr);
    wr(a, {8'h00, bmo_pkg::CMD_PROGRAM});
    wr(a, d);
    pq.push_back(ok ? {1'h1, a, d, arr} : 42'h0);
  endtask : prog
  // Ready marks each valid word; nothing is taken while it is low
  always @(negedge clk)
  begin
    if (rdy === 1'h1)
      check_word("read data", rq.size() ? rq.pop_front() : 16'hxxxx, rdata);
    if (start === 1'h1 || fail === 1'h1)
      check_prog(pq.size() ? pq.pop_front() : 42'hx,
                 {start, start ? {req.addr, req.data, req.to_array} : 41'h0});
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin : main
    repeat (8) @(posedge clk);
    #1 rst_n = 1'h1;
    busy_is(16'h0000);
    repeat (12)
    begin
      seed = lfsr(seed);
      rd(seed[23:0], arr_w(seed[23:0]));
    end
    for (int k = 0; k < 2; k++)
    begin
      code = {seed[15:8], k ? bmo_pkg::CMD_ID_ENTER_B : bmo_pkg::CMD_ID_ENTER_A};
      wr(24'h2000aa, code);
      busy_is(16'h0000);
      wr(24'h0300aa, code);
      busy_is(16'h0001);
      foreach (id_off[j]) rd(24'h030000 | id_off[j],
                             id_off[j] < 16'h00cf ? id_off[j] : 16'h0);
      rd(24'h040010, arr_w(24'h040010));
      rd(24'h930010, arr_w(24'h930010));
      wr(24'h0500aa, code);
      wr(24'h720000, {8'h00, bmo_pkg::CMD_SEC_ENTER});
      busy_is(16'h0001);
      rd(24'h0500aa, arr_w(24'h0500aa));
      prog(24'h030040, 16'h1234, 1'h0, 1'h0);
      seed = lfsr(seed);
      wr(seed[23:0], {seed[15:8], bmo_pkg::CMD_RESET});
      busy_is(16'h0000);
      rd(24'h03001f, arr_w(24'h03001f));
    end
    wr(24'h720000, {8'h00, bmo_pkg::CMD_SEC_ENTER});
    busy_is(16'h0080);
    foreach (sec_off[j]) rd(24'h720000 | sec_off[j],
      sec_off[j] < 16'h0100 ? {sec_off[j][7:0] ^ 8'hc3, sec_off[j][7:0]} : 16'h0);
    prog(24'h720010, 16'h3c3c, 1'h0, 1'h0);
    prog(24'h730090, 16'h3c3c, 1'h0, 1'h0);
    slow = 1'h1;
    prog(24'h720090, seed[15:0], 1'h1, 1'h0);
    busy_is(16'h0080);
    rd(24'h720090, 16'h0000);
    rd(24'h910000, arr_w(24'h910000));
    wr(24'h0300aa, 16'h0098);
    busy_is(16'h0080);
    wr(24'h720000, {8'h00, bmo_pkg::CMD_STATUS});
    rd(24'h720090, 16'h0001);
    idle(48);
    busy_is(16'h0080);
    wr(24'h720000, 16'h00f0);
    busy_is(16'h0000);
    wr(24'ha50000, {8'h00, bmo_pkg::CMD_CFG_ENTER});
    busy_is(16'h0400);
    rd(24'ha50003, {8'h03 ^ 8'hc3, 8'h03});
    rd(24'ha60003, arr_w(24'ha60003));
    wr(24'h100000, 16'h12f0);
    busy_is(16'h0400);
    wr(24'h100000, bmo_pkg::CMD_CFG_EXIT);
    busy_is(16'h0000);
    slow = 1'h0;
    // Low data byte kept off the reset code, which would cancel the program
    prog(24'hc10004, seed[31:16] | 16'h0001, 1'h1, 1'h1);
    busy_is(16'h1000);
    busy_is(16'h0000);
    wr(24'h0300aa, 16'h0090);
    busy_is(16'h0001);
    rst_n = 1'h0;
    @(posedge clk) #1;
    check_word("bank busy in reset", 16'h0000, busy);
    rst_n = 1'h1;
    rd(24'h03001f, arr_w(24'h03001f));
    idle(4);
    check_word("reads outstanding", 16'h0000, 16'(rq.size() + pq.size()));
    summarize();
  end
  initial
  begin : watchdog
    #(25 * 4000);
    errors++;
    summarize();
  end
endmodule : testbench
